// >>> hdl/port_select_status_defs.svh
`ifndef PORT_SELECT_STATUS_DEFS_SVH
`define PORT_SELECT_STATUS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_BC_ERR_COUNT 8'h1B
`define ADDR_PIN_STATUS_LOW 8'h1C
`define ADDR_PIN_STATUS_HIGH 8'h1D
`define ADDR_PORT_SELECT 8'h1E
`define ADDR_FREQ_COUNTER 8'h1F

// ----------------------------------------
// Field positions, masks and reset values
// ----------------------------------------
`define BIT_FIRST_PORT_SELECT 0
`define BIT_SECOND_PORT_SELECT 1
`define BIT_SECOND_ADDRESS_ENABLE 2
`define PORT_SELECT_RESET 3'h1
`define PIN_STATUS_LOW_MASK 8'hEF
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01
`define COUNT_MAX 8'hFF
`define SECOND_ADDR_STEP 7'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define OSC_PERIOD_NS 40
`define OSC_TICK_CYC ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hdl/port_select_status_pkg.sv
package port_select_status_pkg;

    // One register access as decoded by the I2C target
    typedef struct packed {
        logic wr;
        logic rd;
        logic via_second;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_type;

    // Where primary-address accesses to per-port registers go
    typedef struct packed {
        logic [1:0] wr_mask;
        logic rd_second;
    } port_route_type;

    typedef enum logic [0:0] {
        FREQ_IDLE = 1'b0,
        FREQ_COUNTING = 1'b1
    } freq_state_type;

endpackage

// >>> hdl/pixel_frequency_counter.sv
`timescale 1ns/1ns
`include "port_select_status_defs.svh"

module pixel_frequency_counter (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [7:0] i_interval,
    input wire logic i_pixel_edge,
    output logic [7:0] o_count,
    output logic o_busy
);

    port_select_status_pkg::freq_state_type state_r;
    logic [2:0] tick_r;
    logic [7:0] remain_r;
    logic [7:0] run_r;
    logic [7:0] run_nxt;
    logic [7:0] count_r;
    logic tick_done;

    // ----------------------------------------
    // Oscillator time base and edge count
    // ----------------------------------------
    // Oscillator period is derived from i_clk, so it is exact here
    assign tick_done = (tick_r == 3'(`OSC_TICK_CYC - 1));
    // Saturating so a fast pixel clock cannot wrap to a small value
    assign run_nxt = (i_pixel_edge && run_r != `COUNT_MAX) ? run_r + `COUNT_ONE : run_r;

    // Interval sequencing; a new write restarts a running interval
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= port_select_status_pkg::FREQ_IDLE;
            tick_r <= 3'h0;
            remain_r <= `COUNT_ZERO;
            run_r <= `COUNT_ZERO;
            count_r <= `COUNT_ZERO;
        end else if (i_ce) begin
            if (i_start) begin
                tick_r <= 3'h0;
                remain_r <= i_interval;
                run_r <= `COUNT_ZERO;
                if (i_interval == `COUNT_ZERO) begin
                    state_r <= port_select_status_pkg::FREQ_IDLE;
                    count_r <= `COUNT_ZERO;
                end else begin
                    state_r <= port_select_status_pkg::FREQ_COUNTING;
                end
            end else begin
                unique case (state_r)
                    port_select_status_pkg::FREQ_IDLE: begin
                        tick_r <= 3'h0;
                    end
                    port_select_status_pkg::FREQ_COUNTING: begin
                        run_r <= run_nxt;
                        tick_r <= tick_done ? 3'h0 : tick_r + 3'h1;
                        if (tick_done) begin
                            remain_r <= remain_r - `COUNT_ONE;
                            if (remain_r == `COUNT_ONE) begin
                                count_r <= run_nxt;
                                state_r <= port_select_status_pkg::FREQ_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign o_count = count_r;
    assign o_busy = (state_r == port_select_status_pkg::FREQ_COUNTING);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_start_runs;
        i_ce && i_start && i_interval != `COUNT_ZERO |=> o_busy && remain_r == $past(i_interval);
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("frequency interval did not start");

    property p_interval_ends;
        i_ce && !i_start && o_busy && tick_done && remain_r == `COUNT_ONE |=> !o_busy && o_count == $past(run_nxt);
    endproperty
    a_interval_ends: assert property (p_interval_ends) else $error("result not latched at interval end");

    property p_run_holds_max;
        i_ce && !i_start && o_busy && run_r == `COUNT_MAX |=> run_r == `COUNT_MAX;
    endproperty
    a_run_holds_max: assert property (p_run_holds_max) else $error("edge count wrapped");

endmodule // pixel_frequency_counter

// >>> hdl/port_select_status_regs.sv
`timescale 1ns/1ns
`include "port_select_status_defs.svh"

// Behaviour
// - In self-test, count back-channel CRC errors in 8 bits, saturating at 255.
// - Error counter clears on a new self-test run or the external clear control.
// - With second-port select set, the error counter read shows the second port.
// - Low status: pins 7..5 in bits 7..5, pins 3..0 in 3..0; high: pin 8 bit 0.
// - A pin status bit only means something when that pin is an input.
// - With second-port select set, status bits 3..0 show the second link pins.
// - Second-address enable answers a second address, device address plus one.
// - Second-port select: primary writes hit port two and shared; reads likewise.
// - Second-port select steers pin configuration 3..0 to the second link.
// - First-port select: primary writes hit port one and shared; reads likewise.
// - Both selects set: primary-address reads return second-port registers.
// - Second-address enable makes both selects ignored; each address its port, but status bits 3..0 always show the first link.
// - Writing the frequency register starts an interval of value times 40 ns.
// - Reading the frequency register gives edges of the last finished interval.
// - The pixel edge count holds at 0xff once it gets there.

module port_select_status_regs (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire port_select_status_pkg::reg_access_type i_acc,
    input wire logic [6:0] i_device_id,
    input wire logic i_selftest_active,
    input wire logic i_selftest_start,
    input wire logic i_err_clear,
    input wire logic [1:0] i_bc_crc_error,
    input wire logic [8:0] i_pin_level,
    input wire logic [8:0] i_pin_input_mode,
    input wire logic [3:0] i_remote_pin_level,
    input wire logic [3:0] i_remote_pin_input_mode,
    input wire logic i_pixel_edge,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_hit,
    output logic o_second_address_enable,
    output logic [6:0] o_second_address,
    output port_select_status_pkg::port_route_type o_primary_route,
    output logic o_pin_cfg_second_link,
    output logic o_freq_busy
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // True when an access must see second-port contents
    function automatic logic second_view(input logic via_second, input logic [2:0] sel);
        logic result;
        result = 1'b0;
        if (via_second) begin
            result = 1'b1;
        end else if (sel[`BIT_SECOND_ADDRESS_ENABLE]) begin
            result = 1'b0;
        end else begin
            result = sel[`BIT_SECOND_PORT_SELECT];
        end
        return result;
    endfunction

    // Routing of primary-address accesses to per-port registers
    function automatic port_select_status_pkg::port_route_type route_of(input logic [2:0] sel);
        port_select_status_pkg::port_route_type r;
        r.wr_mask = 2'h0;
        r.rd_second = 1'b0;
        if (sel[`BIT_SECOND_ADDRESS_ENABLE]) begin
            r.wr_mask = 2'h1;
        end else begin
            r.wr_mask = {sel[`BIT_SECOND_PORT_SELECT], sel[`BIT_FIRST_PORT_SELECT]};
            r.rd_second = sel[`BIT_SECOND_PORT_SELECT];
        end
        return r;
    endfunction

    // True for offsets owned by this slice
    function automatic logic in_range(input logic [7:0] addr);
        return (addr >= `ADDR_BC_ERR_COUNT) && (addr <= `ADDR_FREQ_COUNTER);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [2:0] port_sel_r;
    logic [7:0] err_count_r [2];
    logic [7:0] pin_low_r;
    logic [7:0] pin_high_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic hit_r;
    logic second_en_r;
    logic [6:0] second_addr_r;
    port_select_status_pkg::port_route_type route_r;
    logic pin_cfg_second_r;
    logic freq_start;
    logic [7:0] freq_count;
    logic freq_busy;
    logic acc_second;
    logic [7:0] pin_low_nxt;
    logic [7:0] rdata_nxt;
    logic err_count_rd_sel;

    assign acc_second = second_view(i_acc.via_second, port_sel_r);

    // ----------------------------------------
    // Port select register
    // ----------------------------------------
    // Only the three control bits are stored, so reserved bits cannot stick
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            port_sel_r <= `PORT_SELECT_RESET;
        end else if (i_ce && i_acc.wr && i_acc.addr == `ADDR_PORT_SELECT) begin
            port_sel_r <= i_acc.wdata[2:0];
        end
    end

    // Second-address enable and routing outputs follow the stored selects; the second address follows the device id
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            second_en_r <= 1'b0;
            second_addr_r <= 7'h00;
            route_r <= '0;
            pin_cfg_second_r <= 1'b0;
        end else if (i_ce) begin
            second_en_r <= port_sel_r[`BIT_SECOND_ADDRESS_ENABLE];
            second_addr_r <= i_device_id + `SECOND_ADDR_STEP;
            route_r <= route_of(port_sel_r);
            pin_cfg_second_r <= second_view(1'b0, port_sel_r);
        end
    end

    // ----------------------------------------
    // Back-channel error counters, one per port
    // ----------------------------------------
    // An error in the clearing cycle is kept, so none is lost
    generate
        for (genvar p = 0; p < 2; p++) begin : g_err
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    err_count_r[p] <= `COUNT_ZERO;
                end else if (i_ce) begin
                    if (i_selftest_start || i_err_clear) begin
                        err_count_r[p] <= (i_selftest_active && i_bc_crc_error[p]) ? `COUNT_ONE : `COUNT_ZERO;
                    end else if (i_selftest_active && i_bc_crc_error[p] && err_count_r[p] != `COUNT_MAX) begin
                        err_count_r[p] <= err_count_r[p] + `COUNT_ONE;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Pin status capture
    // ----------------------------------------
    // Non-input pins read zero; software should disregard them anyway
    always_comb begin
        pin_low_nxt = i_pin_level[7:0] & i_pin_input_mode[7:0];
        if (second_view(1'b0, port_sel_r)) begin
            pin_low_nxt[3:0] = i_remote_pin_level & i_remote_pin_input_mode;
        end
        pin_low_nxt = pin_low_nxt & `PIN_STATUS_LOW_MASK;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_low_r <= `COUNT_ZERO;
            pin_high_r <= `COUNT_ZERO;
        end else if (i_ce) begin
            pin_low_r <= pin_low_nxt;
            pin_high_r <= {7'h00, i_pin_level[8] & i_pin_input_mode[8]};
        end
    end

    // ----------------------------------------
    // Frequency counter
    // ----------------------------------------
    assign freq_start = i_acc.wr && i_acc.addr == `ADDR_FREQ_COUNTER;

    pixel_frequency_counter u_freq (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_start(freq_start),
        .i_interval(i_acc.wdata),
        .i_pixel_edge(i_pixel_edge),
        .o_count(freq_count),
        .o_busy(freq_busy)
    );

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Per-port counter picked by the access view, which unlike the status bits also honours via_second
    assign err_count_rd_sel = acc_second;

    always_comb begin
        rdata_nxt = `COUNT_ZERO;
        unique case (i_acc.addr)
            `ADDR_BC_ERR_COUNT: rdata_nxt = err_count_r[err_count_rd_sel];
            `ADDR_PIN_STATUS_LOW: rdata_nxt = pin_low_r;
            `ADDR_PIN_STATUS_HIGH: rdata_nxt = pin_high_r;
            `ADDR_PORT_SELECT: rdata_nxt = {5'h00, port_sel_r};
            `ADDR_FREQ_COUNTER: rdata_nxt = freq_count;
            default: rdata_nxt = `COUNT_ZERO;
        endcase
    end

    // Answer one cycle after the read; out-of-slice reads leave o_hit low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_r <= `COUNT_ZERO;
            rvalid_r <= 1'b0;
            hit_r <= 1'b0;
        end else if (i_ce) begin
            rvalid_r <= i_acc.rd;
            hit_r <= i_acc.rd && in_range(i_acc.addr);
            if (i_acc.rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_hit = hit_r;
    assign o_second_address_enable = second_en_r;
    assign o_second_address = second_addr_r;
    assign o_primary_route = route_r;
    assign o_pin_cfg_second_link = pin_cfg_second_r;
    assign o_freq_busy = freq_busy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_err_counts;
        i_ce && i_selftest_active && i_bc_crc_error[0] && !i_selftest_start && !i_err_clear
            && err_count_r[0] != `COUNT_MAX |=> err_count_r[0] == $past(err_count_r[0]) + `COUNT_ONE;
    endproperty
    a_err_counts: assert property (p_err_counts) else $error("error counter missed a count");

    property p_err_saturates;
        i_ce && !i_selftest_start && !i_err_clear && err_count_r[1] == `COUNT_MAX |=> err_count_r[1] == `COUNT_MAX;
    endproperty
    a_err_saturates: assert property (p_err_saturates) else $error("error counter wrapped");

    property p_err_clears;
        i_ce && (i_selftest_start || i_err_clear) && !i_bc_crc_error[0] |=> err_count_r[0] == `COUNT_ZERO;
    endproperty
    a_err_clears: assert property (p_err_clears) else $error("error counter did not clear");

    sequence s_read_count_second;
        i_ce && i_acc.rd && i_acc.addr == `ADDR_BC_ERR_COUNT && acc_second;
    endsequence

    property p_read_second_count;
        s_read_count_second |=> o_rvalid && o_hit && o_rdata == $past(err_count_r[1]);
    endproperty
    a_read_second_count: assert property (p_read_second_count) else $error("wrong port counter read");

    property p_status_reserved;
        i_ce && i_acc.rd && i_acc.addr == `ADDR_PIN_STATUS_HIGH |=> o_rdata[7:1] == 7'h00 && o_rvalid;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("reserved status bits set");

    property p_status_second_link;
        i_ce && pin_cfg_second_r && port_sel_r[`BIT_SECOND_PORT_SELECT] && !port_sel_r[`BIT_SECOND_ADDRESS_ENABLE]
            |=> pin_low_r[3:0] == $past(i_remote_pin_level & i_remote_pin_input_mode);
    endproperty
    a_status_second_link: assert property (p_status_second_link) else $error("status not from second link");

    property p_low_pins;
        i_ce |=> pin_low_r[7:5] == $past(i_pin_level[7:5] & i_pin_input_mode[7:5]) && !pin_low_r[4];
    endproperty
    a_low_pins: assert property (p_low_pins) else $error("pin 7..5 status wrong");

    property p_second_address;
        i_ce |=> o_second_address == $past(i_device_id) + `SECOND_ADDR_STEP;
    endproperty
    a_second_address: assert property (p_second_address) else $error("second address not id plus one");

    sequence s_sel_write(logic [2:0] v);
        i_ce && i_acc.wr && i_acc.addr == `ADDR_PORT_SELECT && i_acc.wdata[2:0] == v;
    endsequence

    property p_enable_overrides;
        s_sel_write(3'h7) ##1 i_ce |=> o_primary_route.wr_mask == 2'h1 && !o_primary_route.rd_second;
    endproperty
    a_enable_overrides: assert property (p_enable_overrides) else $error("selects not ignored");

    property p_both_selects;
        s_sel_write(3'h3) ##1 i_ce |=> o_primary_route.wr_mask == 2'h3 && o_primary_route.rd_second;
    endproperty
    a_both_selects: assert property (p_both_selects) else $error("both selects route wrong");

    property p_freq_start;
        i_ce && freq_start && i_acc.wdata != `COUNT_ZERO |=> o_freq_busy;
    endproperty
    a_freq_start: assert property (p_freq_start) else $error("frequency interval not started");

    property p_clear_keeps_error;
        i_ce && (i_selftest_start || i_err_clear) && i_selftest_active && i_bc_crc_error[1]
            |=> err_count_r[1] == `COUNT_ONE;
    endproperty
    a_clear_keeps_error: assert property (p_clear_keeps_error) else $error("error lost while clearing");

    property p_out_of_range;
        i_ce && i_acc.rd && i_acc.addr > `ADDR_FREQ_COUNTER
            |=> o_rvalid && !o_hit && o_rdata == `COUNT_ZERO;
    endproperty
    a_out_of_range: assert property (p_out_of_range) else $error("read outside slice answered");

    property p_enable_mirror;
        i_ce
            |=> o_second_address_enable == $past(port_sel_r[`BIT_SECOND_ADDRESS_ENABLE]);
    endproperty
    a_enable_mirror: assert property (p_enable_mirror) else $error("second address enable wrong");

    property p_pin_eight;
        i_ce |=> pin_high_r[7:1] == 7'h00
            && pin_high_r[0] == $past(i_pin_level[8] && i_pin_input_mode[8]);
    endproperty
    a_pin_eight: assert property (p_pin_eight) else $error("pin 8 status wrong");

    property p_first_link_view;
        i_ce && (port_sel_r[`BIT_SECOND_ADDRESS_ENABLE] || !port_sel_r[`BIT_SECOND_PORT_SELECT])
            |=> pin_low_r[3:0] == $past(i_pin_level[3:0] & i_pin_input_mode[3:0]);
    endproperty
    a_first_link_view: assert property (p_first_link_view) else $error("status not from first link");

endmodule // port_select_status_regs

// >>> verification/reg_host_model.sv
`timescale 1ns/1ns

// Host side of the register path: one decoded access at a time
module reg_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    input wire logic i_hit,
    output port_select_status_pkg::reg_access_type o_acc
);
    initial begin
        o_acc = '0;
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    // Address and data flip after release so a stale value never passes for a live one
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic via);
        @(negedge i_clk);
        o_acc.wr = 1'b1;
        o_acc.via_second = via;
        o_acc.addr = a;
        o_acc.wdata = d;
        @(negedge i_clk);
        o_acc.wr = 1'b0;
        o_acc.addr = ~a;
        o_acc.wdata = ~d;
    endtask

    // Waits a few cycles at most for the answer, so a missing answer shows as ok low
    task automatic read(input logic [7:0] a, input logic via, output logic [7:0] d, output logic h,
                        output logic ok);
        ok = 1'b0;
        d = 8'h00;
        h = 1'b0;
        @(negedge i_clk);
        o_acc.rd = 1'b1;
        o_acc.via_second = via;
        o_acc.addr = a;
        @(negedge i_clk);
        o_acc.rd = 1'b0;
        o_acc.addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                h = i_hit;
                ok = 1'b1;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask
endmodule // reg_host_model

// >>> verification/port_select_status_regs_tb.sv
`timescale 1ns/1ns

module port_select_status_regs_tb;
    logic i_clk, i_reset, i_ce, i_selftest_active, i_selftest_start, i_err_clear, i_pixel_edge;
    logic [6:0] i_device_id;
    logic [1:0] i_bc_crc_error;
    logic [8:0] i_pin_level, i_pin_input_mode;
    logic [3:0] i_remote_pin_level, i_remote_pin_input_mode;
    logic [7:0] o_rdata;
    logic o_rvalid, o_hit, o_second_address_enable, o_pin_cfg_second_link, o_freq_busy;
    logic [6:0] o_second_address;
    port_select_status_pkg::port_route_type o_primary_route;
    port_select_status_pkg::reg_access_type acc;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] rst_exp [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

    port_select_status_regs port_select_status_regs_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_acc(acc), .i_device_id(i_device_id), .i_selftest_active(i_selftest_active),
        .i_selftest_start(i_selftest_start), .i_err_clear(i_err_clear), .i_bc_crc_error(i_bc_crc_error),
        .i_pin_level(i_pin_level), .i_pin_input_mode(i_pin_input_mode), .i_remote_pin_level(i_remote_pin_level),
        .i_remote_pin_input_mode(i_remote_pin_input_mode), .i_pixel_edge(i_pixel_edge), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_hit(o_hit), .o_second_address_enable(o_second_address_enable),
        .o_second_address(o_second_address), .o_primary_route(o_primary_route),
        .o_pin_cfg_second_link(o_pin_cfg_second_link), .o_freq_busy(o_freq_busy));

    reg_host_model reg_host_model_inst (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .i_hit(o_hit),
        .o_acc(acc));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // The whole run needs about 1000 cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Compare and helper tasks
    // ----------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        check8({7'h00, got}, {7'h00, exp}, what);
    endtask

    // Hit is expected only inside the five-register range
    task automatic rd_check(input logic [7:0] a, input logic via, input logic [7:0] exp);
        logic [7:0] d;
        logic h;
        logic ok;
        reg_host_model_inst.read(a, via, d, h, ok);
        check1(ok, 1'b1, "read answer");
        check8(d, exp, "read data");
        check1(h, (a >= 8'h1B && a <= 8'h1F), "hit flag");
    endtask

    // Route outputs lag the register by a cycle, so settle before looking
    task automatic route_check(input logic [7:0] sel, input logic [2:0] exp_route, input logic pcfg,
                               input logic en);
        reg_host_model_inst.write(8'h1E, sel, 1'b0);
        repeat (2) @(negedge i_clk);
        check8({5'h00, o_primary_route}, {5'h00, exp_route}, "primary route");
        check1(o_pin_cfg_second_link, pcfg, "pin config steering");
        check1(o_second_address_enable, en, "second address enable");
    endtask

    task automatic errs(input logic [1:0] m, input int n);
        repeat (n) begin
            @(negedge i_clk);
            i_bc_crc_error = m;
            @(negedge i_clk);
            i_bc_crc_error = 2'b00;
        end
    endtask

    // Pixel edges arrive every cycle, so a finished interval holds five edges per tick
    task automatic freq_run(input logic [7:0] n, input logic [7:0] exp);
        i_pixel_edge = 1'b1;
        reg_host_model_inst.write(8'h1F, n, 1'b0);
        check1(o_freq_busy, n != 8'h00, "interval running");
        for (int i = 0; i < 400 && o_freq_busy === 1'b1; i++) @(negedge i_clk);
        i_pixel_edge = 1'b0;
        check1(o_freq_busy, 1'b0, "interval ended");
        rd_check(8'h1F, 1'b0, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_device_id = 7'h2A;
        i_selftest_active = 1'b0;
        i_selftest_start = 1'b0;
        i_err_clear = 1'b0;
        i_bc_crc_error = 2'b00;
        i_pin_level = 9'h000;
        i_pin_input_mode = 9'h000;
        i_remote_pin_level = 4'h0;
        i_remote_pin_input_mode = 4'h0;
        i_pixel_edge = 1'b0;
        repeat (6) @(negedge i_clk);
        i_reset = 1'b0;
        // Reset values, unmapped places and a write to a read-only place
        for (int i = 0; i < 5; i++) rd_check(8'h1B + i[7:0], 1'b0, rst_exp[i]);
        rd_check(8'h20, 1'b0, 8'h00);
        rd_check(8'h1A, 1'b0, 8'h00);
        reg_host_model_inst.write(8'h1B, 8'h55, 1'b0);
        rd_check(8'h1B, 1'b0, 8'h00);
        reg_host_model_inst.write(8'h1E, 8'hFF, 1'b0);
        rd_check(8'h1E, 1'b0, 8'h07);
        check8({1'b0, o_second_address}, 8'h2B, "second address");
        // Port steering for select values 1, 2, 0, 3 and 7
        route_check(8'h01, 3'b010, 1'b0, 1'b0);
        route_check(8'h02, 3'b101, 1'b1, 1'b0);
        check1(o_pin_cfg_second_link, 1'b1, "second link pins");
        route_check(8'h00, 3'b000, 1'b0, 1'b0);
        route_check(8'h03, 3'b111, 1'b1, 1'b0);
        route_check(8'h07, 3'b010, 1'b0, 1'b1);
        // Pin status, with the reserved bit driven high underneath
        i_pin_level = 9'h1FF;
        i_pin_input_mode = 9'h17A;
        i_remote_pin_level = 4'hF;
        i_remote_pin_input_mode = 4'h5;
        reg_host_model_inst.write(8'h1E, 8'h01, 1'b0);
        rd_check(8'h1C, 1'b0, 8'h6A);
        rd_check(8'h1D, 1'b0, 8'h01);
        i_pin_input_mode = 9'h07A;
        rd_check(8'h1D, 1'b0, 8'h00);
        reg_host_model_inst.write(8'h1E, 8'h02, 1'b0);
        rd_check(8'h1C, 1'b0, 8'h65);
        // Back-channel error counting per port
        reg_host_model_inst.write(8'h1E, 8'h01, 1'b0);
        i_selftest_active = 1'b1;
        errs(2'b01, 3);
        errs(2'b10, 1);
        rd_check(8'h1B, 1'b0, 8'h03);
        reg_host_model_inst.write(8'h1E, 8'h02, 1'b0);
        rd_check(8'h1B, 1'b0, 8'h01);
        reg_host_model_inst.write(8'h1E, 8'h07, 1'b0);
        rd_check(8'h1B, 1'b0, 8'h03);
        rd_check(8'h1B, 1'b1, 8'h01);
        i_selftest_active = 1'b0;
        errs(2'b01, 2);
        rd_check(8'h1B, 1'b0, 8'h03);
        @(negedge i_clk);
        i_err_clear = 1'b1;
        @(negedge i_clk);
        i_err_clear = 1'b0;
        rd_check(8'h1B, 1'b0, 8'h00);
        rd_check(8'h1B, 1'b1, 8'h00);
        i_selftest_active = 1'b1;
        errs(2'b10, 2);
        i_selftest_start = 1'b1;
        @(negedge i_clk);
        i_selftest_start = 1'b0;
        rd_check(8'h1B, 1'b1, 8'h00);
        // An error in the clearing cycle must survive the clear
        i_bc_crc_error = 2'b10;
        i_err_clear = 1'b1;
        @(negedge i_clk);
        i_bc_crc_error = 2'b00;
        i_err_clear = 1'b0;
        rd_check(8'h1B, 1'b1, 8'h01);
        errs(2'b01, 260);
        rd_check(8'h1B, 1'b0, 8'hFF);
        // Clock enable low must freeze the counters
        i_ce = 1'b0;
        errs(2'b10, 3);
        i_ce = 1'b1;
        rd_check(8'h1B, 1'b1, 8'h01);
        // Pixel clock frequency measurement
        freq_run(8'h02, 8'h0A);
        freq_run(8'h01, 8'h05);
        freq_run(8'h3C, 8'hFF);
        freq_run(8'h00, 8'h00);
        tally_and_finish();
    end
endmodule // port_select_status_regs_tb
